// ### design/pfio_pkg.sv
// pfio_pkg: register map, field positions and reset values of the
// eight-pin general-purpose port with analog, segment and comparator
// overrides.
// assumes: one 40 MHz system clock, plain register port with 4-bit index.
package pfio_pkg;

  // ------------------------------------------------------------------
  // port geometry
  // ------------------------------------------------------------------
  localparam int unsigned PFIO_PINS = 8;
  localparam int unsigned PFIO_ANALOG_PINS = 7;
  localparam int unsigned PFIO_ADDR_W = 4;
  localparam int unsigned PFIO_DATA_W = 8;

  // ------------------------------------------------------------------
  // register indices on the register port
  // ------------------------------------------------------------------
  localparam logic [3:0] PFIO_IDX_DIRECTION = 4'h0;
  localparam logic [3:0] PFIO_IDX_PIN_READ = 4'h1;
  localparam logic [3:0] PFIO_IDX_OUTPUT_LATCH = 4'h2;
  localparam logic [3:0] PFIO_IDX_ANALOG_CFG = 4'h3;
  localparam logic [3:0] PFIO_IDX_CMP_CONTROL = 4'h4;
  localparam logic [3:0] PFIO_IDX_VREF_CONTROL = 4'h5;
  localparam logic [3:0] PFIO_IDX_SEG_GROUP2 = 4'h6;
  localparam logic [3:0] PFIO_IDX_SEG_GROUP3 = 4'h7;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] PFIO_RST_DIRECTION = 8'hFF;
  localparam logic [7:0] PFIO_RST_LATCH = 8'h00;
  localparam logic [7:0] PFIO_RST_ANALOG_CFG = 8'h00;
  localparam logic [7:0] PFIO_RST_CMP_CONTROL = 8'h00;
  localparam logic [7:0] PFIO_RST_VREF_CONTROL = 8'h00;
  localparam logic [7:0] PFIO_RST_SEG = 8'h00;
  localparam logic [7:0] PFIO_READ_NONE = 8'h00;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  // analog_pin_config: ref select bits 5:4, pin config field 3:0
  localparam logic [7:0] PFIO_ANALOG_CFG_MASK = 8'h3F;
  localparam int unsigned PFIO_PCFG_LSB = 0;
  localparam logic [3:0] PFIO_PCFG_TOP = 4'hE;
  localparam logic [3:0] PFIO_FIRST_CHANNEL = 4'h5;
  // comparator_control
  localparam int unsigned PFIO_CMP_TWO_RESULT_BIT = 7;
  localparam int unsigned PFIO_CMP_ONE_RESULT_BIT = 6;
  localparam int unsigned PFIO_CMP_TWO_INV_BIT = 5;
  localparam int unsigned PFIO_CMP_ONE_INV_BIT = 4;
  localparam int unsigned PFIO_CMP_MODE_LSB = 0;
  localparam logic [7:0] PFIO_CMP_WRITE_MASK = 8'h3F;
  localparam logic [2:0] PFIO_CMP_MODE_OUTPUTS = 3'h3;
  localparam logic [2:0] PFIO_CMP_MODE_OFF = 3'h7;
  // voltage_ref_control
  localparam int unsigned PFIO_VREF_ENABLE_BIT = 7;
  localparam int unsigned PFIO_VREF_OUT_BIT = 6;
  // segment enables: pin n carries segment 18 plus n
  localparam int unsigned PFIO_SEG_GROUP2_LSB = 2;
  localparam int unsigned PFIO_SEG_GROUP2_PINS = 6;
  localparam int unsigned PFIO_SEG_GROUP3_PINS = 2;

  // ------------------------------------------------------------------
  // pin numbers with dedicated functions
  // ------------------------------------------------------------------
  localparam int unsigned PFIO_PIN_CMP_TWO = 1;
  localparam int unsigned PFIO_PIN_CMP_ONE = 2;
  localparam int unsigned PFIO_PIN_VREF = 5;
  localparam int unsigned PFIO_PIN_SLAVE_SEL = 7;

endpackage

// ### design/pfio_pin_mux.sv
// pfio_pin_mux: per-pin drive priority (segment, reference, direction,
// comparator result, latch). purely combinational.
// assumes: the caller registers the outputs before they reach the pads.
`timescale 1ns/1ps
`default_nettype none
module pfio_pin_mux
  import pfio_pkg::*;
(
  // stored configuration
  input wire logic [7:0] direction_in,
  input wire logic [7:0] latch_in,
  input wire logic [7:0] seg_enable_in,
  // peripheral overrides
  input wire logic vref_out_in,
  input wire logic cmp_out_sel_in,
  input wire logic cmp_one_in,
  input wire logic cmp_two_in,
  // pad drive
  output logic [7:0] drive_data_out,
  output logic [7:0] drive_en_out
);

  // ------------------------------------------------------------------
  // drive selection
  // ------------------------------------------------------------------
  // analog selection is not an input here, so it cannot alter drive
  always_comb
  begin
    drive_data_out = latch_in;
    drive_en_out = ~direction_in;
    if (cmp_out_sel_in)
    begin
      drive_data_out[PFIO_PIN_CMP_TWO] = cmp_two_in;
      drive_data_out[PFIO_PIN_CMP_ONE] = cmp_one_in;
    end
    if (vref_out_in)
    begin
      drive_en_out[PFIO_PIN_VREF] = 1'b0;
    end
    drive_en_out = drive_en_out & ~seg_enable_in;
  end

endmodule
`default_nettype wire

// ### design/pfio_pin_sampler.sv
// pfio_pin_sampler: registers the pad levels once per clock and hands
// the slave-select level on.
// assumes: pad inputs are synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module pfio_pin_sampler
  import pfio_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // pad levels
  input wire logic [7:0] pin_level_in,
  // sampled levels
  output logic [7:0] sample_out,
  output logic slave_select_out
);

  logic [7:0] sample_q;
  logic [7:0] sample_d;
  logic slave_sel_q;
  logic slave_sel_d;

  // ------------------------------------------------------------------
  // sampling
  // ------------------------------------------------------------------
  // the top pin always feeds the serial slave select, whatever else
  always_comb
  begin
    sample_d = pin_level_in;
    slave_sel_d = pin_level_in[PFIO_PIN_SLAVE_SEL];
  end

  // samples reset to zero, slave select to one, so a read right after reset shows no stale level
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sample_q <= 8'h00;
      slave_sel_q <= 1'b1;
    end
    else
    begin
      sample_q <= sample_d;
      slave_sel_q <= slave_sel_d;
    end
  end

  assign sample_out = sample_q;
  assign slave_select_out = slave_sel_q;

endmodule
`default_nettype wire

// ### design/pfio_port.sv
// pfio_port: eight-pin bidirectional port with direction, latch and
// pin-read registers, analog channel selection, segment and comparator
// overrides, and the serial slave-select feed from the top pin.
// assumes: a plain register port (index, data, one-cycle strobes) and
// pads resolved outside from data and enable; one 40 MHz clock.
//
// How it works
// - eight pins, input or output, shared registers
// - direction one puts driver in high impedance
// - direction zero drives latch unless overridden
// - latch register reads back latch, not pins
// - after reset low seven inputs read zero
// - after reset low seven are analog channels
// - segment enable kills pin's digital function
// - pin n carries segment eighteen plus n
// - comparator two result drives pin one
// - comparator one result drives pin two
// - pin five off when segment or reference
// - analog selection leaves output value unchanged
// - top pin feeds slave select, set input
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pfio_port
  import pfio_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  // pads
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_out,
  // comparator raw results from the analog side
  input wire logic cmp_one_raw_in,
  input wire logic cmp_two_raw_in,
  // controls toward the analog, display and serial blocks
  output logic [6:0] analog_select_out,
  output logic [7:0] segment_enable_out,
  output logic [2:0] cmp_mode_out,
  output logic vref_pin_enable_out,
  output logic slave_select_out
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // channel k is analog while the config field is at most 14 - k;
  // the field value 15 turns every channel digital, zero all analog
  function automatic logic [6:0] analog_mask(input logic [3:0] pcfg);
    logic [6:0] m;
    logic [3:0] chan;
    m = 7'h00;
    for (int i = 0; i < PFIO_ANALOG_PINS; i++)
    begin
      chan = PFIO_FIRST_CHANNEL + 4'(i);
      m[i] = (pcfg <= (PFIO_PCFG_TOP - chan));
    end
    return m;
  endfunction

  // one strobe decode used by every register
  function automatic logic hit(input logic strobe, input logic [3:0] addr,
                               input logic [3:0] idx);
    return strobe && (addr == idx);
  endfunction

  // ------------------------------------------------------------------
  // register state
  // ------------------------------------------------------------------
  logic [7:0] direction_q;
  logic [7:0] direction_d;
  logic [7:0] latch_q;
  logic [7:0] latch_d;
  logic [7:0] analog_cfg_q;
  logic [7:0] analog_cfg_d;
  logic [7:0] cmp_ctrl_q;
  logic [7:0] cmp_ctrl_d;
  logic [7:0] vref_ctrl_q;
  logic [7:0] vref_ctrl_d;
  logic [7:0] seg_group2_q;
  logic [7:0] seg_group2_d;
  logic [7:0] seg_group3_q;
  logic [7:0] seg_group3_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // ------------------------------------------------------------------
  // pad and control output state
  // ------------------------------------------------------------------
  logic [7:0] pin_out_q;
  logic [7:0] pin_out_d;
  logic [7:0] pin_oe_q;
  logic [7:0] pin_oe_d;
  logic [6:0] analog_sel_q;
  logic [6:0] analog_sel_d;
  logic [7:0] seg_en_q;
  logic [7:0] seg_en_d;
  logic [2:0] cmp_mode_q;
  logic [2:0] cmp_mode_d;
  logic vref_pin_q;
  logic vref_pin_d;

  // ------------------------------------------------------------------
  // derived terms
  // ------------------------------------------------------------------
  logic [7:0] seg_enable;
  logic [6:0] analog_now;
  logic cmp_one_result;
  logic cmp_two_result;
  logic cmp_out_sel;
  logic vref_out;
  logic [7:0] drive_data;
  logic [7:0] drive_en;
  logic [7:0] sample;
  logic [7:0] pin_read_value;

  // pin n sits on segment 18 + n: bits 7:2 of group two, 1:0 of three
  assign seg_enable = {
    seg_group3_q[PFIO_SEG_GROUP3_PINS-1:0],
    seg_group2_q[PFIO_SEG_GROUP2_LSB +: PFIO_SEG_GROUP2_PINS]
  };

  assign analog_now = analog_mask(analog_cfg_q[PFIO_PCFG_LSB +: 4]);

  // result polarity follows the invert bits
  assign cmp_one_result = cmp_one_raw_in ^ cmp_ctrl_q[PFIO_CMP_ONE_INV_BIT];
  assign cmp_two_result = cmp_two_raw_in ^ cmp_ctrl_q[PFIO_CMP_TWO_INV_BIT];
  assign cmp_out_sel =
    (cmp_ctrl_q[PFIO_CMP_MODE_LSB +: 3] == PFIO_CMP_MODE_OUTPUTS);

  // reference reaches the pin only while both enable and output are on
  assign vref_out = vref_ctrl_q[PFIO_VREF_ENABLE_BIT]
                  && vref_ctrl_q[PFIO_VREF_OUT_BIT];

  // analog pins read as zero; the top pin has no analog channel
  assign pin_read_value = sample & {1'b1, ~analog_now};

  // ------------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------------
  pfio_pin_mux u_mux (
    .direction_in(direction_q),
    .latch_in(latch_q),
    .seg_enable_in(seg_enable),
    .vref_out_in(vref_out),
    .cmp_out_sel_in(cmp_out_sel),
    .cmp_one_in(cmp_one_result),
    .cmp_two_in(cmp_two_result),
    .drive_data_out(drive_data),
    .drive_en_out(drive_en)
  );

  pfio_pin_sampler u_sampler (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .pin_level_in(pin_in),
    .sample_out(sample),
    .slave_select_out(slave_select_out)
  );

  // ------------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------------
  // overrides only reach the mux, so stored bits stay as written
  always_comb
  begin
    direction_d = direction_q;
    latch_d = latch_q;
    analog_cfg_d = analog_cfg_q;
    cmp_ctrl_d = cmp_ctrl_q;
    vref_ctrl_d = vref_ctrl_q;
    seg_group2_d = seg_group2_q;
    seg_group3_d = seg_group3_q;
    if (hit(reg_write_in, reg_addr_in, PFIO_IDX_DIRECTION))
    begin
      direction_d = reg_wdata_in;
    end
    // both the latch and the pin-read index land in the latch
    if (hit(reg_write_in, reg_addr_in, PFIO_IDX_OUTPUT_LATCH)
        || hit(reg_write_in, reg_addr_in, PFIO_IDX_PIN_READ))
    begin
      latch_d = reg_wdata_in;
    end
    if (hit(reg_write_in, reg_addr_in, PFIO_IDX_ANALOG_CFG))
    begin
      analog_cfg_d = reg_wdata_in & PFIO_ANALOG_CFG_MASK;
    end
    // result bits are live, never stored
    if (hit(reg_write_in, reg_addr_in, PFIO_IDX_CMP_CONTROL))
    begin
      cmp_ctrl_d = reg_wdata_in & PFIO_CMP_WRITE_MASK;
    end
    if (hit(reg_write_in, reg_addr_in, PFIO_IDX_VREF_CONTROL))
    begin
      vref_ctrl_d = reg_wdata_in;
    end
    if (hit(reg_write_in, reg_addr_in, PFIO_IDX_SEG_GROUP2))
    begin
      seg_group2_d = reg_wdata_in;
    end
    if (hit(reg_write_in, reg_addr_in, PFIO_IDX_SEG_GROUP3))
    begin
      seg_group3_d = reg_wdata_in;
    end
  end

  // power-on state: all inputs, low seven analog, comparators reset
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      direction_q <= PFIO_RST_DIRECTION;
      latch_q <= PFIO_RST_LATCH;
      analog_cfg_q <= PFIO_RST_ANALOG_CFG;
      cmp_ctrl_q <= PFIO_RST_CMP_CONTROL;
      vref_ctrl_q <= PFIO_RST_VREF_CONTROL;
      seg_group2_q <= PFIO_RST_SEG;
      seg_group3_q <= PFIO_RST_SEG;
    end
    else
    begin
      direction_q <= direction_d;
      latch_q <= latch_d;
      analog_cfg_q <= analog_cfg_d;
      cmp_ctrl_q <= cmp_ctrl_d;
      vref_ctrl_q <= vref_ctrl_d;
      seg_group2_q <= seg_group2_d;
      seg_group3_q <= seg_group3_d;
    end
  end

  // ------------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------------
  // data stand for exactly the cycle after the strobe, zero otherwise
  always_comb
  begin
    rdata_d = PFIO_READ_NONE;
    if (reg_read_in)
    begin
      unique case (reg_addr_in)
        PFIO_IDX_DIRECTION: rdata_d = direction_q;
        PFIO_IDX_PIN_READ: rdata_d = pin_read_value;
        PFIO_IDX_OUTPUT_LATCH: rdata_d = latch_q;
        PFIO_IDX_ANALOG_CFG: rdata_d = analog_cfg_q;
        PFIO_IDX_CMP_CONTROL:
        begin
          rdata_d = cmp_ctrl_q;
          rdata_d[PFIO_CMP_TWO_RESULT_BIT] = cmp_two_result;
          rdata_d[PFIO_CMP_ONE_RESULT_BIT] = cmp_one_result;
        end
        PFIO_IDX_VREF_CONTROL: rdata_d = vref_ctrl_q;
        PFIO_IDX_SEG_GROUP2: rdata_d = seg_group2_q;
        PFIO_IDX_SEG_GROUP3: rdata_d = seg_group3_q;
        default: rdata_d = PFIO_READ_NONE; // unmapped index
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rdata_q <= PFIO_READ_NONE;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // ------------------------------------------------------------------
  // pad and control outputs
  // ------------------------------------------------------------------
  // one register stage after configuration; costs a cycle of latency
  // but keeps the pads glitch free while several bits change at once
  always_comb
  begin
    pin_out_d = drive_data;
    pin_oe_d = drive_en;
    analog_sel_d = analog_now;
    seg_en_d = seg_enable;
    cmp_mode_d = cmp_ctrl_q[PFIO_CMP_MODE_LSB +: 3];
    vref_pin_d = vref_out;
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pin_out_q <= 8'h00;
      pin_oe_q <= 8'h00;
      analog_sel_q <= 7'h7F;
      seg_en_q <= 8'h00;
      cmp_mode_q <= 3'h0;
      vref_pin_q <= 1'b0;
    end
    else
    begin
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
      analog_sel_q <= analog_sel_d;
      seg_en_q <= seg_en_d;
      cmp_mode_q <= cmp_mode_d;
      vref_pin_q <= vref_pin_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign pin_out = pin_out_q;
  assign pin_oe_out = pin_oe_q;
  assign analog_select_out = analog_sel_q;
  assign segment_enable_out = seg_en_q;
  assign cmp_mode_out = cmp_mode_q;
  assign vref_pin_enable_out = vref_pin_q;

endmodule
`default_nettype wire

// ### verification/pfio_pad_model.sv
// pfio_pad_model: outside circuitry on the eight pads of the port.
// assumes: the bench sets the outside levels and which pads it drives.
`timescale 1ns/1ps
`default_nettype none
module pfio_pad_model
(
  // clock
  input wire logic clk_sys_in,
  // port drive
  input wire logic [7:0] pin_out_in,
  input wire logic [7:0] pin_oe_in,
  // outside sources
  input wire logic [7:0] ext_val_in,
  input wire logic [7:0] ext_en_in,
  // resolved pad level
  output logic [7:0] pin_level_out
);
  logic [7:0] last_q = 8'h00;

  // an undriven pad shows the inverse of its last level, so a read of a
  // floating pin never matches by luck
  always_comb
  begin
    pin_level_out = ~last_q;
    for (int n = 0; n < 8; n++)
    begin
      if (pin_oe_in[n])
        pin_level_out[n] = pin_out_in[n];
      else if (ext_en_in[n])
        pin_level_out[n] = ext_val_in[n];
    end
  end

  // remember the level for the floating case
  always @(posedge clk_sys_in)
    last_q <= pin_level_out;
endmodule
`default_nettype wire

// ### verification/pfio_port_checker.sv
// pfio_port_checker: concurrent checks on the port's pads and registers.
// assumes: bound into pfio_port; one clock, async active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pfio_port_checker
  import pfio_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  // pads and controls
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_oe_out,
  input wire logic [6:0] analog_select_out,
  input wire logic [7:0] segment_enable_out,
  input wire logic vref_pin_enable_out,
  input wire logic slave_select_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  // ----------------------------------------------------------------
  // drive overrides
  // ----------------------------------------------------------------
  // one cycle of slack kept, though enables and pad drive land on the same edge
  a_seg_no_drive: assert property (
    (segment_enable_out & $past(segment_enable_out) & pin_oe_out) == 8'h00)
    else $error("segment pin still driven");
  a_vref_no_drive: assert property (
    vref_pin_enable_out && $past(vref_pin_enable_out) |-> !pin_oe_out[5])
    else $error("reference pin still driven");

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  a_latch_readback: assert property (
    reg_read_in && reg_addr_in == PFIO_IDX_OUTPUT_LATCH && $past(reg_write_in)
    && $past(reg_addr_in) == PFIO_IDX_OUTPUT_LATCH
    |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("latch read differs from write");
  a_pinread_to_latch: assert property (
    reg_read_in && reg_addr_in == PFIO_IDX_OUTPUT_LATCH && $past(reg_write_in)
    && $past(reg_addr_in) == PFIO_IDX_PIN_READ
    |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("pin-read write missed latch");
  a_rdata_idle: assert property (
    !$past(reg_read_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (
    reg_read_in && reg_addr_in[3] |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_analog_reads_zero: assert property (
    reg_read_in && reg_addr_in == PFIO_IDX_PIN_READ
    && $stable(analog_select_out)
    |=> (reg_rdata_out[6:0] & analog_select_out) == 7'h00)
    else $error("analog pin read not zero");

  // ----------------------------------------------------------------
  // reset and slave select
  // ----------------------------------------------------------------
  a_reset_inputs: assert property (
    $fell(sys_rst_in) |-> pin_oe_out == 8'h00 ##1 pin_oe_out == 8'h00)
    else $error("pad driven right after reset");
  a_reset_analog: assert property (
    $fell(sys_rst_in) |-> analog_select_out == 7'h7F)
    else $error("low pins not analog after reset");
  a_slave_follow: assert property (
    !$past(sys_rst_in) |-> slave_select_out == $past(pin_in[7]))
    else $error("slave select not pin seven");

  // main scenarios
  c_seg_write: cover property (reg_write_in
    && reg_addr_in == PFIO_IDX_SEG_GROUP2);
  c_vref_on: cover property (vref_pin_enable_out);
  c_pin_read: cover property (reg_read_in
    && reg_addr_in == PFIO_IDX_PIN_READ);
endmodule

bind pfio_port pfio_port_checker pfio_port_checker_i (
  .clk_sys_in(clk_sys_in),
  .sys_rst_in(sys_rst_in),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in),
  .reg_rdata_out(reg_rdata_out),
  .pin_in(pin_in),
  .pin_oe_out(pin_oe_out),
  .analog_select_out(analog_select_out),
  .segment_enable_out(segment_enable_out),
  .vref_pin_enable_out(vref_pin_enable_out),
  .slave_select_out(slave_select_out)
);
`default_nettype wire

// ### verification/tb.sv
// tb: self-checking bench for pfio_port; tasks drive the register port,
// the pad model stands in for the outside circuitry.
// assumes: package, design, checker and pad model compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb
  import pfio_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_write_in = 1'b0;
  logic reg_read_in = 1'b0;
  logic cmp_one_raw_in = 1'b0;
  logic cmp_two_raw_in = 1'b0;
  logic [7:0] reg_rdata_out, pin_in, pin_out, pin_oe_out;
  logic [7:0] segment_enable_out;
  logic [6:0] analog_select_out;
  logic [2:0] cmp_mode_out;
  logic vref_pin_enable_out, slave_select_out;
  logic rd_d = 1'b0;
  logic vref_on = 1'b0;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] dir, lat, seg, e;
  logic [5:0] cmp;
  logic [7:0] exp_q[$];
  logic [7:0] rst_tab [9];
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;

  always #12.5 clk_sys_in = ~clk_sys_in;

  pfio_port pfio_port_i (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_out(pin_oe_out), .cmp_one_raw_in(cmp_one_raw_in),
    .cmp_two_raw_in(cmp_two_raw_in), .analog_select_out(analog_select_out),
    .segment_enable_out(segment_enable_out), .cmp_mode_out(cmp_mode_out),
    .vref_pin_enable_out(vref_pin_enable_out),
    .slave_select_out(slave_select_out));

  pfio_pad_model pfio_pad_model_i (
    .clk_sys_in(clk_sys_in), .pin_out_in(pin_out), .pin_oe_in(pin_oe_out),
    .ext_val_in(ext_val), .ext_en_in(8'hFF), .pin_level_out(pin_in));

  // ----------------------------------------------------------------
  // expectations from the shadow of what software wrote
  // ----------------------------------------------------------------
  function automatic logic [7:0] exp_oe();
    return ~dir & ~seg & (vref_on ? 8'hDF : 8'hFF);
  endfunction

  function automatic logic [7:0] exp_out();
    logic [7:0] v;
    v = lat;
    if (cmp[2:0] == PFIO_CMP_MODE_OUTPUTS)
    begin
      v[1] = cmp_two_raw_in ^ cmp[5];
      v[2] = cmp_one_raw_in ^ cmp[4];
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic cmp8(input logic [7:0] got, input logic [7:0] want);
    check_count++;
    if (got !== want)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  // one bus cycle; strobes held to the next edge
  task automatic bus(input logic w, input logic r, input logic [3:0] a,
                     input logic [7:0] d);
    reg_write_in <= w;
    reg_read_in <= r;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask

  // pads settle two edges after a write
  task automatic chk_pins();
    repeat (3) bus(1'b0, 1'b0, 4'h0, 8'h00);
    cmp8(pin_oe_out, exp_oe());
    cmp8(pin_out & exp_oe(), exp_out() & exp_oe());
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // read data watcher: one result the cycle after each read strobe
  always @(posedge clk_sys_in)
  begin
    if (rd_d)
      cmp8(reg_rdata_out, exp_q.pop_front());
    rd_d <= reg_read_in;
  end

  // hang guard, far above what the tests need
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      results();
    end
  end

  initial
  begin
    dir = PFIO_RST_DIRECTION;
    lat = PFIO_RST_LATCH;
    seg = 8'h00;
    cmp = 6'h00;
    ext_val = 8'($urandom(32'hA2794317));
    repeat (12) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    rst_tab = '{PFIO_RST_DIRECTION, {ext_val[7], 7'h00}, PFIO_RST_LATCH,
      PFIO_RST_ANALOG_CFG, PFIO_RST_CMP_CONTROL, PFIO_RST_VREF_CONTROL,
      PFIO_RST_SEG, PFIO_RST_SEG, PFIO_READ_NONE};
    for (int i = 0; i < 9; i++)
      rd(i[3:0], rst_tab[i]);
    chk_pins();
    cmp8({1'b0, analog_select_out}, 8'h7F);
    $display("done: reset values");
    // digital set-up, latch and pin-read paths
    cmp = 6'h07;
    wr(PFIO_IDX_CMP_CONTROL, 8'h07);
    wr(PFIO_IDX_ANALOG_CFG, 8'h0F);
    dir = 8'hCF;
    wr(PFIO_IDX_DIRECTION, dir);
    lat = 8'($urandom);
    wr(PFIO_IDX_OUTPUT_LATCH, lat);
    rd(PFIO_IDX_OUTPUT_LATCH, lat);
    chk_pins();
    rd(PFIO_IDX_PIN_READ, (lat & exp_oe()) | (ext_val & ~exp_oe()));
    lat = 8'($urandom);
    wr(PFIO_IDX_PIN_READ, lat);
    rd(PFIO_IDX_OUTPUT_LATCH, lat);
    dir = 8'h00;
    wr(PFIO_IDX_DIRECTION, dir);
    wr(PFIO_IDX_ANALOG_CFG, 8'h00);
    chk_pins();
    rd(PFIO_IDX_PIN_READ, {lat[7], 7'h00});
    wr(PFIO_IDX_ANALOG_CFG, 8'h09);
    rd(PFIO_IDX_PIN_READ, {lat[7:1], 1'b0});
    wr(PFIO_IDX_ANALOG_CFG, 8'h0F);
    $display("done: latch and pins");
    // each segment in turn takes its pin away from the port
    for (int n = 0; n < 8; n++)
    begin
      seg = 8'h01 << n;
      wr(PFIO_IDX_SEG_GROUP2, {seg[5:0], 2'b00});
      wr(PFIO_IDX_SEG_GROUP3, {6'h00, seg[7:6]});
      chk_pins();
      cmp8(segment_enable_out, seg);
    end
    seg = 8'h00;
    wr(PFIO_IDX_SEG_GROUP2, 8'h00);
    wr(PFIO_IDX_SEG_GROUP3, 8'h00);
    rd(PFIO_IDX_DIRECTION, dir);
    rd(PFIO_IDX_OUTPUT_LATCH, lat);
    $display("done: segments");
    // reference output needs both enables
    vref_on = 1'b1;
    wr(PFIO_IDX_VREF_CONTROL, 8'hC0);
    chk_pins();
    cmp8({7'h00, vref_pin_enable_out}, 8'h01);
    vref_on = 1'b0;
    wr(PFIO_IDX_VREF_CONTROL, 8'h80);
    chk_pins();
    $display("done: reference");
    // every mix of raw result and invert on the comparator outputs
    for (int i = 0; i < 16; i++)
    begin
      cmp = {i[3:2], 4'h3};
      cmp_two_raw_in <= i[1];
      cmp_one_raw_in <= i[0];
      wr(PFIO_IDX_CMP_CONTROL, {2'b11, cmp});
      chk_pins();
      e = exp_out();
      rd(PFIO_IDX_CMP_CONTROL, {e[1], e[2], cmp});
      cmp8({5'h00, cmp_mode_out}, 8'h03);
    end
    cmp = 6'h07;
    wr(PFIO_IDX_CMP_CONTROL, 8'h07);
    chk_pins();
    $display("done: comparator outputs");
    // top pin as input feeds slave select
    dir = 8'h80;
    wr(PFIO_IDX_DIRECTION, dir);
    for (int i = 0; i < 4; i++)
    begin
      ext_val <= 8'($urandom);
      chk_pins();
      cmp8({7'h00, slave_select_out}, {7'h00, ext_val[7]});
      rd(PFIO_IDX_PIN_READ, {ext_val[7], lat[6:0]});
    end
    repeat (3) bus(1'b0, 1'b0, 4'h0, 8'h00);
    $display("done: slave select");
    results();
  end
endmodule
`default_nettype wire
